// ### dfs_device.sv
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "dfs_params.svh"
// Contract
// - Steering enabled only after loop lock
// - Closed loop steers digital, else analog
// - Step resolution finer than 0.001 ppb
// - 38-bit deviation added/subtracted per step
// - Deviation word accepts full 38-bit range
// - Each update register write applies step
// - Write 0 raises, 1 lowers frequency
// - Software steps always available
// - Trigger rising edge applies one step
// - Direction 0 positive, 1 negative
// - Trigger pulse high above 100 ns
// - Pin step rate below 5 MHz
// - Disable clears accumulated offset
// - Absolute write sets feedback numerator
// - Denominator zero means two to 40
// - Free-run disconnects, free-run word still steers
// - Analog steering needs loop enable, mode
// - Absolute analog numerator base plus word
// - Effective analog numerator readable
// - Relative mode ramps by step, period
// - New word restarts ramp
// - Completion flag when ramp done
// - 45-bit signed phase offset, reset zero
module dfs_device (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  clkEn,
  dfs_link_if.dev                    link,
  output      dfs_pkg::dfs_num_type  fbNumEff,
  output      logic [`DFS_NUM_W:0]   fbDenEff,
  output      dfs_pkg::dfs_num_type  anaNumEff,
  output      dfs_pkg::dfs_phase_type phaseOffset,
  output      logic                  rampDone
);
  import dfs_pkg::*;

  function automatic logic [39:0] merge40(input logic [39:0] old, input logic [31:0] d, input logic hi);
    merge40 = hi ? {d[7:0], old[31:0]} : {old[39:32], d};
  endfunction : merge40

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0]                ctrl_q;
  logic [`DFS_DEV_W-1:0]     dev_q;
  logic [39:0]               fbNum_q;
  logic [39:0]               fbDen_q;
  logic [39:0]               aBase_q;
  logic [39:0]               freeRun_q;
  logic [39:0]               rStep_q;
  logic [`DFS_CNT_W-1:0]     rPer_q;
  logic [`DFS_PH_W-1:0]      phOff_q;
  logic [`DFS_SEL_W-1:0]     trigSel_q;
  logic [`DFS_SEL_W-1:0]     dirSel_q;

  wire wr = link.regWr & clkEn;
  wire [`DFS_ADDR_W-1:0] a = link.regAddr;
  wire [31:0] wd = link.regWdata;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q    <= '0;
      dev_q     <= '0;
      fbNum_q   <= '0;
      fbDen_q   <= '0;
      aBase_q   <= '0;
      freeRun_q <= '0;
      rStep_q   <= '0;
      rPer_q    <= '0;
      phOff_q   <= '0;
      trigSel_q <= '0;
      dirSel_q  <= '0;
    end else if (wr) begin
      case (a)
        `DFS_A_CTRL:       ctrl_q <= wd[7:0];
        `DFS_A_DEV_LO:     dev_q <= {dev_q[37:32], wd};
        `DFS_A_DEV_HI:     dev_q <= {wd[5:0], dev_q[31:0]};
        `DFS_A_FBNUM_LO:   fbNum_q <= merge40(fbNum_q, wd, 1'b0);
        `DFS_A_FBNUM_HI:   fbNum_q <= merge40(fbNum_q, wd, 1'b1);
        `DFS_A_FBDEN_LO:   fbDen_q <= merge40(fbDen_q, wd, 1'b0);
        `DFS_A_FBDEN_HI:   fbDen_q <= merge40(fbDen_q, wd, 1'b1);
        `DFS_A_ABASE_LO:   aBase_q <= merge40(aBase_q, wd, 1'b0);
        `DFS_A_ABASE_HI:   aBase_q <= merge40(aBase_q, wd, 1'b1);
        `DFS_A_FREERUN_LO: freeRun_q <= merge40(freeRun_q, wd, 1'b0);
        `DFS_A_FREERUN_HI: freeRun_q <= merge40(freeRun_q, wd, 1'b1);
        `DFS_A_RSTEP_LO:   rStep_q <= merge40(rStep_q, wd, 1'b0);
        `DFS_A_RSTEP_HI:   rStep_q <= merge40(rStep_q, wd, 1'b1);
        `DFS_A_RPER:       rPer_q <= wd[`DFS_CNT_W-1:0];
        `DFS_A_PHOFF_LO:   phOff_q <= {phOff_q[44:32], wd};
        `DFS_A_PHOFF_HI:   phOff_q <= {wd[12:0], phOff_q[31:0]};
        `DFS_A_PINSEL: begin
          trigSel_q <= wd[1:0];
          dirSel_q  <= wd[9:8];
        end
        default: ;
      endcase
    end
  end

  wire steerEn  = ctrl_q[`DFS_C_STEER_EN] & ctrl_q[`DFS_C_LOCKED];
  wire histEn   = ctrl_q[`DFS_C_HIST_EN];
  wire anaOk    = ctrl_q[`DFS_C_LOOP_EN] & ctrl_q[`DFS_C_DEN_MODE];
  wire closed   = ctrl_q[`DFS_C_CLOSED] & ctrl_q[`DFS_C_DLOOP_EN];
  wire pinEn    = ctrl_q[`DFS_C_PIN_EN];

  // ----------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [`DFS_PIN_W-1:0] s1_q;
  logic [`DFS_PIN_W-1:0] s2_q;
  logic [`DFS_PIN_W-1:0] s3_q;
  logic                  trigLvl_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (clkEn) begin
      s1_q <= link.stepPins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level changes only when stages two and three agree
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trigLvl_q <= 1'b0;
    end else if (clkEn && (s2_q[trigSel_q] == s3_q[trigSel_q])) begin
      trigLvl_q <= s3_q[trigSel_q];
    end
  end

  wire trigRise = clkEn && (s2_q[trigSel_q] == s3_q[trigSel_q]) && s3_q[trigSel_q] && !trigLvl_q;
  wire pinStep  = pinEn & trigRise;
  wire pinDown  = s3_q[dirSel_q];
  wire swStep   = wr && (a == `DFS_A_UPDATE);
  wire swDown   = wd[`DFS_U_DEC];

  // ----------------------------------------------------------------
  // Digital feedback deviation accumulator
  // ----------------------------------------------------------------
  logic [39:0] acc_q;
  logic [39:0] devExt;
  logic [39:0] delta;

  always_comb begin
    devExt = {2'b00, dev_q};
    delta  = '0;
    if (swStep) begin
      delta = swDown ? (delta - devExt) : (delta + devExt);
    end
    if (pinStep) begin
      delta = pinDown ? (delta - devExt) : (delta + devExt);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= '0;
    end else if (clkEn) begin
      if (!steerEn || (wr && (a == `DFS_A_FBNUM_LO || a == `DFS_A_FBNUM_HI))) begin
        acc_q <= '0;
      end else if (closed) begin
        acc_q <= acc_q + delta;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fbNumEff <= '0;
      fbDenEff <= '0;
    end else if (clkEn) begin
      fbNumEff <= fbNum_q + acc_q;
      fbDenEff <= (fbDen_q == 40'h0) ? {1'b1, 40'h0} : {1'b0, fbDen_q};
    end
  end

  // ----------------------------------------------------------------
  // Analog numerator steering with ramp
  // ----------------------------------------------------------------
  logic [39:0]           applied_q;
  logic [39:0]           target_q;
  logic [`DFS_CNT_W-1:0] perCnt_q;
  logic [39:0]           remain;
  logic [39:0]           stepMag;
  logic                  remNeg;

  wire frWrite = wr && (a == `DFS_A_FREERUN_LO || a == `DFS_A_FREERUN_HI);

  always_comb begin
    remain  = target_q - applied_q;
    remNeg  = remain[39];
    stepMag = remNeg ? (40'h0 - remain) : remain;
    if (stepMag > rStep_q) begin
      stepMag = rStep_q;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      applied_q <= '0;
      target_q  <= '0;
      perCnt_q  <= '0;
      rampDone  <= 1'b0;
    end else if (clkEn) begin
      if (frWrite && histEn) begin
        target_q <= applied_q + merge40(freeRun_q, wd, a == `DFS_A_FREERUN_HI);
        perCnt_q <= rPer_q;
        rampDone <= 1'b0;
      end else if (!histEn) begin
        applied_q <= freeRun_q;
        target_q  <= freeRun_q;
        rampDone  <= 1'b1;
      end else if (remain == 40'h0) begin
        rampDone <= 1'b1;
      end else if (perCnt_q != '0) begin
        perCnt_q <= perCnt_q - 1'b1;
      end else begin
        applied_q <= remNeg ? (applied_q - stepMag) : (applied_q + stepMag);
        perCnt_q  <= rPer_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      anaNumEff <= '0;
    end else if (clkEn) begin
      anaNumEff <= (anaOk && !closed) ? (aBase_q + applied_q) : aBase_q;
    end
  end

  assign phaseOffset = phOff_q;

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (clkEn && link.regRd) begin
      case (a)
        `DFS_A_CTRL:     rdata_q <= {24'h0, ctrl_q};
        `DFS_A_DEV_LO:   rdata_q <= dev_q[31:0];
        `DFS_A_DEV_HI:   rdata_q <= {26'h0, dev_q[37:32]};
        `DFS_A_FBNUM_LO: rdata_q <= fbNum_q[31:0];
        `DFS_A_FBNUM_HI: rdata_q <= {24'h0, fbNum_q[39:32]};
        `DFS_A_PHOFF_LO: rdata_q <= phOff_q[31:0];
        `DFS_A_PHOFF_HI: rdata_q <= {19'h0, phOff_q[44:32]};
        `DFS_A_STATUS:   rdata_q <= {30'h0, steerEn, rampDone};
        `DFS_A_ANUM_LO:  rdata_q <= anaNumEff[31:0];
        `DFS_A_ANUM_HI:  rdata_q <= {24'h0, anaNumEff[39:32]};
        default:         rdata_q <= 32'h0;
      endcase
    end
  end

  assign link.regRdata = rdata_q;
endmodule : dfs_device

// ### dfs_host.sv
`timescale 1ns/1ps
`include "dfs_params.svh"
module dfs_host (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   clkEn,
  dfs_link_if.host                    link,
  input  wire logic                   cmdWr,
  input  wire logic                   cmdRd,
  input  wire dfs_pkg::dfs_addr_type  cmdAddr,
  input  wire dfs_pkg::dfs_data_type  cmdWdata,
  output      dfs_pkg::dfs_data_type  cmdRdata,
  input  wire logic                   pulseReq,
  input  wire logic                   pulseDown,
  input  wire logic [`DFS_SEL_W-1:0]  trigPin,
  input  wire logic [`DFS_SEL_W-1:0]  dirPin,
  output      logic                   pulseBusy
);
  import dfs_pkg::*;

  // ----------------------------------------------------------------
  // Register pass-through
  // ----------------------------------------------------------------
  logic                   wr_q;
  logic                   rd_q;
  logic [`DFS_ADDR_W-1:0] addr_q;
  logic [31:0]            wdata_q;
  logic [31:0]            rdata_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (clkEn) begin
      wr_q    <= cmdWr;
      rd_q    <= cmdRd & ~cmdWr;
      addr_q  <= cmdAddr;
      wdata_q <= cmdWdata;
    end
  end

  // Device answers one cycle after the forwarded strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (clkEn) begin
      rdata_q <= link.regRdata;
    end
  end

  assign link.regWr    = wr_q;
  assign link.regRd    = rd_q;
  assign link.regAddr  = addr_q;
  assign link.regWdata = wdata_q;
  assign cmdRdata      = rdata_q;

  // ----------------------------------------------------------------
  // Step pulse generator
  // ----------------------------------------------------------------
  localparam int HighCyc = `DFS_TRIG_MIN_CYC + 1;
  localparam int PerCyc  = (`DFS_RATE_MIN_CYC > 2 * HighCyc) ? `DFS_RATE_MIN_CYC : 2 * HighCyc;

  dfs_pulse_state_type   state_q;
  logic [7:0]            cnt_q;
  logic                  dir_q;
  logic [`DFS_SEL_W-1:0] tsel_q;
  logic [`DFS_SEL_W-1:0] dsel_q;
  logic [`DFS_PIN_W-1:0] pins_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= DFS_H_IDLE;
      cnt_q   <= '0;
      dir_q   <= 1'b0;
      tsel_q  <= '0;
      dsel_q  <= '0;
    end else if (clkEn) begin
      case (state_q)
        DFS_H_IDLE: begin
          if (pulseReq) begin
            state_q <= DFS_H_HIGH;
            cnt_q   <= 8'(HighCyc);
            dir_q   <= pulseDown;
            tsel_q  <= trigPin;
            dsel_q  <= dirPin;
          end
        end
        DFS_H_HIGH: begin
          if (cnt_q == 8'h01) begin
            state_q <= DFS_H_LOW;
            cnt_q   <= 8'(PerCyc - HighCyc);
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        DFS_H_LOW: begin
          if (cnt_q <= 8'h01) begin
            state_q <= DFS_H_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: state_q <= DFS_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pins_q <= '0;
    end else if (clkEn) begin
      pins_q <= '0;
      if (state_q != DFS_H_IDLE) begin
        pins_q[dsel_q] <= dir_q;
      end
      if (state_q == DFS_H_HIGH) begin
        pins_q[tsel_q] <= 1'b1;
      end
    end
  end

  assign link.stepPins = pins_q;
  assign pulseBusy     = (state_q != DFS_H_IDLE);
endmodule : dfs_host

// ### dfs_link_if.sv
`timescale 1ns/1ps
`include "dfs_params.svh"
interface dfs_link_if;
  logic                   regWr;
  logic                   regRd;
  logic [`DFS_ADDR_W-1:0] regAddr;
  logic [31:0]            regWdata;
  logic [31:0]            regRdata;
  logic [`DFS_PIN_W-1:0]  stepPins;

  modport dev (
    input  regWr, regRd, regAddr, regWdata, stepPins,
    output regRdata
  );
  modport host (
    output regWr, regRd, regAddr, regWdata, stepPins,
    input  regRdata
  );
endinterface : dfs_link_if

// ### dfs_params.svh
`ifndef DFS_PARAMS_SVH
`define DFS_PARAMS_SVH

// Word widths
`define DFS_DEV_W        38
`define DFS_NUM_W        40
`define DFS_PH_W         45
`define DFS_UPD_W        8
`define DFS_PIN_W        4
`define DFS_SEL_W        2
`define DFS_CNT_W        16

// Register addresses of the device's own interface
`define DFS_ADDR_W       5
`define DFS_A_CTRL       5'h00
`define DFS_A_DEV_LO     5'h01
`define DFS_A_DEV_HI     5'h02
`define DFS_A_FBNUM_LO   5'h03
`define DFS_A_FBNUM_HI   5'h04
`define DFS_A_FBDEN_LO   5'h05
`define DFS_A_FBDEN_HI   5'h06
`define DFS_A_ABASE_LO   5'h07
`define DFS_A_ABASE_HI   5'h08
`define DFS_A_FREERUN_LO 5'h09
`define DFS_A_FREERUN_HI 5'h0A
`define DFS_A_RSTEP_LO   5'h0B
`define DFS_A_RSTEP_HI   5'h0C
`define DFS_A_RPER       5'h0D
`define DFS_A_PHOFF_LO   5'h0E
`define DFS_A_PHOFF_HI   5'h0F
`define DFS_A_UPDATE     5'h10
`define DFS_A_PINSEL     5'h11
`define DFS_A_STATUS     5'h12
`define DFS_A_ANUM_LO    5'h13
`define DFS_A_ANUM_HI    5'h14

// Control register bit positions
`define DFS_C_STEER_EN   0
`define DFS_C_LOCKED     1
`define DFS_C_HIST_EN    2
`define DFS_C_LOOP_EN    3
`define DFS_C_DEN_MODE   4
`define DFS_C_DLOOP_EN   5
`define DFS_C_PIN_EN     6
`define DFS_C_CLOSED     7

// Update register field
`define DFS_U_DEC        0

// Timing
`define DFS_CLK_NS       100
`define DFS_TRIG_MIN_NS  100
`define DFS_TRIG_MIN_CYC ((`DFS_TRIG_MIN_NS + `DFS_CLK_NS - 1) / `DFS_CLK_NS)
`define DFS_RATE_MAX_KHZ 5000
`define DFS_RATE_MIN_CYC (((1000000 / `DFS_RATE_MAX_KHZ) + `DFS_CLK_NS - 1) / `DFS_CLK_NS)

`endif

// ### dfs_pkg.sv
`include "dfs_params.svh"
package dfs_pkg;
  typedef logic [`DFS_ADDR_W-1:0] dfs_addr_type;
  typedef logic [31:0]            dfs_data_type;
  typedef logic [`DFS_NUM_W-1:0]  dfs_num_type;
  typedef logic [`DFS_PH_W-1:0]   dfs_phase_type;
  typedef enum logic [1:0] {
    DFS_H_IDLE = 2'b00,
    DFS_H_HIGH = 2'b01,
    DFS_H_LOW  = 2'b10
  } dfs_pulse_state_type;
endpackage : dfs_pkg

// ### dfs_steer_asserts.sv
`timescale 1ns/1ps
`include "dfs_params.svh"
module dfs_steer_asserts (
  input wire logic                   core_clk,
  input wire logic                   resetn,
  input wire logic                   clkEn,
  input wire logic                   regWr,
  input wire logic                   regRd,
  input wire logic [`DFS_ADDR_W-1:0] regAddr,
  input wire logic [31:0]            regWdata,
  input wire logic [31:0]            regRdata,
  input wire logic [`DFS_PIN_W-1:0]  stepPins,
  input wire dfs_pkg::dfs_num_type   fbNumEff,
  input wire dfs_pkg::dfs_num_type   anaNumEff,
  input wire dfs_pkg::dfs_phase_type phaseOffset,
  input wire logic                   rampDone
);
  import dfs_pkg::*;
  // ----
  // Register shadow
  // ----
  logic [31:0]        shadow_q [32];
  dfs_num_type        expStep_q;
  wire logic          wrOk    = regWr && clkEn;
  wire logic          upd     = wrOk && regAddr == `DFS_A_UPDATE;
  wire logic          steerOn = shadow_q[0][0] && shadow_q[0][1] && shadow_q[0][5] && shadow_q[0][7];
  wire logic          anaOn   = shadow_q[0][3] && shadow_q[0][4] && !(shadow_q[0][5] && shadow_q[0][7]);
  wire dfs_num_type   devW    = {2'h0, shadow_q[2][5:0], shadow_q[1]};
  wire dfs_num_type   fbNum   = {shadow_q[4][7:0], shadow_q[3]};
  wire dfs_num_type   aSum    = {shadow_q[8][7:0], shadow_q[7]} + {shadow_q[10][7:0], shadow_q[9]};
  wire dfs_phase_type phW     = {shadow_q[15][12:0], shadow_q[14]};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        shadow_q[i] <= '0;
      end
    end else if (wrOk) begin
      shadow_q[regAddr] <= regWdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      expStep_q <= '0;
    end else if (upd) begin
      expStep_q <= regWdata[0] ? fbNumEff - devW : fbNumEff + devW;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_unmapped_read: assert property (regRd && clkEn && regAddr > `DFS_A_ANUM_HI |=> regRdata == '0)
    else $error("unmapped read not zero");
  a_reset_phase: assert property ($rose(resetn) |-> phaseOffset == '0)
    else $error("phase offset not zero after reset");
  a_update_step: assert property (upd && steerOn |-> ##[1:3] fbNumEff == expStep_q)
    else $error("update step wrong");
  a_no_lock_hold: assert property (upd && !steerOn |=> $stable(fbNumEff) [*3])
    else $error("step applied while steering inactive");
  a_disable_clear: assert property (wrOk && regAddr == `DFS_A_CTRL && !regWdata[0] |-> ##[1:3] fbNumEff == fbNum)
    else $error("offset kept after disable");
  a_analog_abs: assert property (wrOk && regAddr == `DFS_A_FREERUN_HI && anaOn && !shadow_q[0][2]
    |-> ##[1:3] anaNumEff == aSum)
    else $error("analog numerator not base plus word");
  a_anum_read: assert property (regRd && clkEn && regAddr == `DFS_A_ANUM_LO ##1 $stable(anaNumEff)
    |-> regRdata == anaNumEff[31:0])
    else $error("analog numerator readback wrong");
  a_phase_load: assert property (wrOk && regAddr == `DFS_A_PHOFF_HI |-> ##[1:3] phaseOffset == phW)
    else $error("phase offset not loaded");

  c_ramp_done: cover property ($rose(rampDone));
  c_pin_step: cover property ($rose(stepPins[0]));
  c_update: cover property (upd && steerOn);
endmodule : dfs_steer_asserts

// ### dfs_steering_bench.sv
`timescale 1ns/1ps
`include "dfs_params.svh"
module dfs_steering_bench;
  import dfs_pkg::*;
  // ----
  // Bench
  // ----
  logic          core_clk = 1'b0, resetn = 1'b0, clkEn = 1'b1, cmdWr = 1'b0, cmdRd = 1'b0;
  logic          pulseReq = 1'b0, pulseDown = 1'b0, pulseBusy, rampDone;
  logic [1:0]    trigPin = 2'h0, dirPin = 2'h1, rdPipe = 2'h0;
  dfs_addr_type  cmdAddr = '0;
  dfs_data_type  cmdWdata = '0, cmdRdata;
  logic [40:0]   fbDenEff;
  dfs_num_type   fbNumEff, anaNumEff, fbNum, acc, base, a0;
  dfs_phase_type phaseOffset, ph;
  logic [37:0]   dev;
  logic [31:0]   expQ [$];
  int            nErrors = 0, totalChecks = 0, seed = 59131, cycles = 0, hiCnt = 0, gap = 100;
  dfs_link_if link ();

  dfs_host u_dfs_host (
    .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .link(link), .cmdWr(cmdWr), .cmdRd(cmdRd),
    .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdRdata(cmdRdata), .pulseReq(pulseReq),
    .pulseDown(pulseDown), .trigPin(trigPin), .dirPin(dirPin), .pulseBusy(pulseBusy));
  dfs_device u_dfs_device (
    .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .link(link), .fbNumEff(fbNumEff),
    .fbDenEff(fbDenEff), .anaNumEff(anaNumEff), .phaseOffset(phaseOffset), .rampDone(rampDone));
  dfs_steer_asserts u_dfs_steer_asserts (
    .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .regWr(link.regWr), .regRd(link.regRd),
    .regAddr(link.regAddr), .regWdata(link.regWdata), .regRdata(link.regRdata),
    .stepPins(link.stepPins), .fbNumEff(fbNumEff), .anaNumEff(anaNumEff),
    .phaseOffset(phaseOffset), .rampDone(rampDone));

  always #50 core_clk = ~core_clk;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic endSim();
    $display("checks=%0d errors=%0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : endSim

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic wr(input dfs_addr_type a, input dfs_data_type d);
    @(posedge core_clk);
    cmdWr <= 1'b1;
    cmdAddr <= a;
    cmdWdata <= d;
    @(posedge core_clk);
    cmdWr <= 1'b0;
  endtask : wr

  task automatic wr2(input dfs_addr_type a, input logic [63:0] v);
    wr(a, v[31:0]);
    wr(a + 5'h01, v[63:32]);
  endtask : wr2

  task automatic rd(input dfs_addr_type a, input dfs_data_type e);
    expQ.push_back(e);
    @(posedge core_clk);
    cmdRd <= 1'b1;
    cmdAddr <= a;
    @(posedge core_clk);
    cmdRd <= 1'b0;
  endtask : rd

  // Read results, pin waveform and run limit
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    rdPipe <= {rdPipe[0], link.regRd};
    hiCnt <= link.stepPins[trigPin] ? hiCnt + 1 : 0;
    gap <= (link.stepPins[trigPin] && hiCnt == 0) ? 0 : gap + 1;
    if (rdPipe[1]) begin
      check(cmdRdata, expQ.pop_front());
    end
    if (link.stepPins[trigPin] && hiCnt == 0) begin
      check(link.stepPins[dirPin], pulseDown);
      check(gap > 1, 1);
    end
    if (!link.stepPins[trigPin] && hiCnt > 0) begin
      check(hiCnt > 1, 1);
    end
    if (cycles == 20000) begin
      nErrors++;
      endSim();
    end
  end

  initial begin
    acc = '0;
    fbNum = {8'($random(seed)), 32'($random(seed))};
    dev = 38'h3F_FFFF_FFFF;
    tick(10);
    resetn <= 1'b1;
    tick(1);
    check(phaseOffset, 0);
    rd(5'h15, 32'h0);
    rd(`DFS_A_ANUM_LO, 32'h0);
    wr2(`DFS_A_FBNUM_LO, 64'(fbNum));
    wr2(`DFS_A_DEV_LO, 64'(dev));
    wr(`DFS_A_CTRL, 32'hA1);
    wr(`DFS_A_UPDATE, 32'h0);
    tick(4);
    check(fbNumEff, fbNum);
    wr(`DFS_A_CTRL, 32'hE3);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 4; k++) begin
        wr(`DFS_A_UPDATE, 32'(k % 2));
        tick(4);
        acc = (k % 2) ? acc - dev : acc + dev;
        check(fbNumEff, 40'(fbNum + acc));
      end
      dev = 38'($random(seed));
      wr2(`DFS_A_DEV_LO, 64'(dev));
    end
    for (int i = 0; i < 4; i++) begin
      trigPin <= 2'(i);
      dirPin <= 2'(i + 1);
      pulseDown <= i[1];
      wr(`DFS_A_PINSEL, {22'h0, 2'(i + 1), 6'h0, 2'(i)});
      @(posedge core_clk);
      pulseReq <= 1'b1;
      @(posedge core_clk);
      pulseReq <= 1'b0;
      tick(1);
      for (int w = 0; w < 50 && pulseBusy !== 1'b0; w++) begin
        tick(1);
      end
      tick(8);
      acc = i[1] ? acc - dev : acc + dev;
      check(fbNumEff, 40'(fbNum + acc));
    end
    wr(`DFS_A_CTRL, 32'h82);
    tick(4);
    check(fbNumEff, fbNum);
    wr(`DFS_A_CTRL, 32'hE3);
    wr(`DFS_A_UPDATE, 32'h0);
    fbNum = {8'($random(seed)), 32'($random(seed))};
    wr2(`DFS_A_FBNUM_LO, 64'(fbNum));
    tick(4);
    check(fbNumEff, fbNum);
    wr2(`DFS_A_FBDEN_LO, 64'h0);
    tick(3);
    check(fbDenEff, 41'h100_0000_0000);
    wr2(`DFS_A_FBDEN_LO, 64'(fbNum));
    tick(3);
    check(fbDenEff, {1'b0, fbNum});
    // Free-running analog steering, digital step refused
    wr(`DFS_A_CTRL, 32'h1B);
    wr(`DFS_A_UPDATE, 32'h0);
    tick(4);
    check(fbNumEff, fbNum);
    base = {8'($random(seed)), 32'($random(seed))};
    a0 = {8'hF0, 32'($random(seed))};
    wr2(`DFS_A_ABASE_LO, 64'(base));
    wr2(`DFS_A_FREERUN_LO, 64'(a0));
    tick(4);
    a0 = a0 + base;
    check(anaNumEff, a0);
    rd(`DFS_A_ANUM_HI, {24'h0, a0[39:32]});
    // Ramp, restarted before its first step is applied
    wr2(`DFS_A_FREERUN_LO, 64'h0);
    wr2(`DFS_A_RSTEP_LO, 64'h5);
    wr(`DFS_A_RPER, 32'h3C);
    wr(`DFS_A_CTRL, 32'h1F);
    wr(`DFS_A_FREERUN_LO, 32'h28);
    tick(30);
    a0 = anaNumEff;
    wr(`DFS_A_FREERUN_LO, 32'h11);
    tick(3);
    check(rampDone, 1'b0);
    for (int w = 0; w < 400 && rampDone !== 1'b1; w++) begin
      tick(1);
    end
    check(rampDone, 1'b1);
    check(anaNumEff, 40'(a0 + 40'h11));
    ph = {13'($random(seed)), 32'($random(seed))};
    wr2(`DFS_A_PHOFF_LO, 64'(ph));
    tick(3);
    check(phaseOffset, ph);
    // Frozen clock enable drops a write
    clkEn <= 1'b0;
    wr(`DFS_A_PHOFF_LO, 32'h0);
    clkEn <= 1'b1;
    tick(4);
    check(phaseOffset, ph);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(1);
    check(phaseOffset, 0);
    endSim();
  end
endmodule : dfs_steering_bench
